/* File: src/pwm_group_pkg.sv */
// Function
// RULE1: unit enable clear gates count clocks off and drops all timer register writes
// RULE2: setting unit enable supplies count clocks with every channel still stopped
// RULE3: software sets the prescaler select register before configuring channels
// RULE4: software sets mode registers, master period value and both slave duty values
// RULE5: software sets each slave output mode bit to one
// RULE6: software clears both slave output level bits during initialisation
// RULE7: software writes each slave output value bit to choose the idle pin level
// RULE8: software sets both slave output enable bits so the timer drives the outputs
// RULE9: pin stays undriven until port latch and port mode are both zero
// RULE10: a stopped channel keeps its slave output at its output value bit
// RULE11: on restart software sets both slave output enable bits again before start
// RULE12: software starts master and both slaves in one write to the start register
// RULE13: start bits are one-shot triggers and always read back as zero
// RULE14: start sets the run status bits of the master and the slaves
// RULE15: master starts and raises its period event at once; slaves start on it
// RULE16: master counts down from period; at zero it raises its event and reloads
// RULE17: slave loads duty on master event, counts down, at zero signals and stops
// RULE18: slave output active one count clock after master event, inactive at zero
// RULE19: duty above period plus one keeps the output active the whole period
// RULE20: stop trigger clears run status, freezes counters, keeps output levels
// RULE21: new period and duty values take effect only when counters reload
`default_nettype none
package pwm_group_pkg;
  localparam int ADDR_W = 8;
  localparam int CNT_W = 16;
  localparam logic [7:0] PER_EN_OFS = 8'h00;
  localparam logic [7:0] PRESCALE_OFS = 8'h04;
  localparam logic [7:0] MMODE_OFS = 8'h08;
  localparam logic [7:0] SMODE_OFS = 8'h0C;
  localparam logic [7:0] PERIOD_OFS = 8'h10;
  localparam logic [7:0] DUTY1_OFS = 8'h14;
  localparam logic [7:0] DUTY2_OFS = 8'h18;
  localparam logic [7:0] OUTMODE_OFS = 8'h1C;
  localparam logic [7:0] START_OFS = 8'h20;
  localparam logic [7:0] STOP_OFS = 8'h24;
  localparam logic [7:0] STATUS_OFS = 8'h28;
  localparam logic [7:0] PORT_OFS = 8'h2C;
  localparam logic [7:0] MCOUNT_OFS = 8'h30;
  localparam logic [7:0] SCOUNT1_OFS = 8'h34;
  localparam logic [7:0] SCOUNT2_OFS = 8'h38;
  localparam int OUT_MODE_LSB = 0;
  localparam int OUT_LVL_LSB = 2;
  localparam int OUT_VAL_LSB = 4;
  localparam int OUT_EN_LSB = 6;
  localparam int PORT_LATCH_LSB = 0;
  localparam int PORT_MODE_LSB = 2;
  localparam logic [3:0] PORT_RST = 4'hC;
  localparam logic [15:0] PSC_RST = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic {SLV_IDLE = 1'b0, SLV_COUNT = 1'b1} slvState_e;
  typedef struct packed {
    logic mode;
    logic level;
    logic enable;
  } slaveCfg_s;
endpackage
`default_nettype wire

/* File: src/pwm_prescaler.sv */
`timescale 1ns/1ns
`default_nettype none
module pwm_prescaler (
  input wire logic clk,
  input wire logic rstn,
  input wire logic en,
  input wire logic [15:0] sel,
  output logic [3:0] tick
);
  import pwm_group_pkg::*;

  logic [15:0] div_ff, nxt_div;
  logic [3:0] tick_ff, nxt_tick;

  function automatic logic [15:0] divMask(input logic [3:0] s);
    divMask = 16'((17'h0_0001 << s) - 17'h0_0001);
  endfunction

  // ----------------------------------------
  // divider: count clock k pulses every 2^sel cycles
  // ----------------------------------------
  always_comb
  begin
    nxt_div = en ? div_ff + 16'h0001 : 16'h0000; // RULE1
    for (int k = 0; k < 4; k++)
    begin
      nxt_tick[k] = en && ((div_ff & divMask(sel[4*k +: 4])) == divMask(sel[4*k +: 4]));
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      div_ff <= 16'h0000;
      tick_ff <= 4'h0;
    end
    else
    begin
      div_ff <= nxt_div;
      tick_ff <= nxt_tick;
    end
  end

  assign tick = tick_ff;
endmodule // pwm_prescaler
`default_nettype wire

/* File: src/pwm_slave_channel.sv */
`timescale 1ns/1ns
`default_nettype none
module pwm_slave_channel (
  input wire logic clk,
  input wire logic rstn,
  input wire logic clear,
  input wire logic tick,
  input wire logic mEvt,
  input wire logic run,
  input wire logic [pwm_group_pkg::CNT_W-1:0] duty,
  input wire pwm_group_pkg::slaveCfg_s cfg,
  input wire logic valWr,
  input wire logic valIn,
  output logic toBit,
  output logic [pwm_group_pkg::CNT_W-1:0] cnt,
  output logic dutyEnd
);
  import pwm_group_pkg::*;

  slvState_e state_ff, nxt_state;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic to_ff, nxt_to;
  logic end_ff, nxt_end;
  logic drive;

  // ----------------------------------------
  // duty counter and output level
  // ----------------------------------------
  always_comb
  begin
    drive = cfg.mode && cfg.enable;
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_to = to_ff; // RULE10
    nxt_end = 1'b0;
    if (clear)
    begin
      nxt_state = SLV_IDLE;
      nxt_cnt = '0;
      nxt_to = 1'b0;
    end
    else
    begin
      if (valWr)
      begin
        nxt_to = valIn;
      end
      if (run)
      begin
        if (mEvt)
        begin
          nxt_cnt = duty; // RULE17 RULE21
          nxt_state = SLV_COUNT;
          // duty equal to period ends on the same count clock as the reload
          if (tick && state_ff == SLV_COUNT && cnt_ff == '0)
          begin
            nxt_end = 1'b1; // RULE17
            if (drive)
            begin
              nxt_to = cfg.level; // RULE18
            end
          end
        end
        else if (tick)
        begin
          case (state_ff)
            SLV_COUNT:
            begin
              if (cnt_ff == '0)
              begin
                nxt_state = SLV_IDLE; // RULE17
                nxt_end = 1'b1;
                if (drive)
                begin
                  nxt_to = cfg.level; // RULE18
                end
              end
              else
              begin
                nxt_cnt = cnt_ff - 16'h0001;
                if (drive)
                begin
                  nxt_to = ~cfg.level; // RULE18 RULE19
                end
              end
            end
            default:
            begin
              nxt_state = SLV_IDLE;
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_ff <= SLV_IDLE;
      cnt_ff <= '0;
      to_ff <= 1'b0;
      end_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      to_ff <= nxt_to;
      end_ff <= nxt_end;
    end
  end

  assign toBit = to_ff;
  assign cnt = cnt_ff;
  assign dutyEnd = end_ff;
endmodule // pwm_slave_channel
`default_nettype wire

/* File: src/multi_pwm_timer_group.sv */
// Chosen here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module multi_pwm_timer_group (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [pwm_group_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [pwm_group_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [1:0] pwmOut,
  output logic [1:0] pwmDriveN
);
  import pwm_group_pkg::*;

  function automatic logic regHit(input logic [ADDR_W-1:0] a);
    regHit = (a[1:0] == 2'h0) && (a <= SCOUNT2_OFS);
  endfunction

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    for (int b = 0; b < 4; b++)
    begin
      wmerge[8*b +: 8] = s[b] ? d[8*b +: 8] : old[8*b +: 8];
    end
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic awHeld_ff, nxt_awHeld, wHeld_ff, nxt_wHeld;
  logic [ADDR_W-1:0] awAddr_ff, nxt_awAddr;
  logic [31:0] wData_ff, nxt_wData;
  logic [3:0] wStrb_ff, nxt_wStrb;
  logic awready_ff, nxt_awready, wready_ff, nxt_wready;
  logic bvalid_ff, nxt_bvalid, arready_ff, nxt_arready, rvalid_ff, nxt_rvalid;
  logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic [31:0] rdata_ff, nxt_rdata, rdMux;
  logic perEn_ff, nxt_perEn;
  logic [15:0] psc_ff, nxt_psc;
  logic [1:0] mMode_ff, nxt_mMode, sMode_ff, nxt_sMode;
  logic [CNT_W-1:0] period_ff, nxt_period, mCnt_ff, nxt_mCnt;
  logic [CNT_W-1:0] duty_ff [2];
  logic [CNT_W-1:0] nxt_duty [2];
  logic [CNT_W-1:0] sCnt [2];
  logic [7:0] outMode_ff, nxt_outMode;
  logic [3:0] port_ff, nxt_port;
  logic [2:0] run_ff, nxt_run;
  logic mEvtQ_ff, nxt_mEvtQ;
  logic [1:0] pwmOut_ff, nxt_pwmOut, pwmDriveN_ff, nxt_pwmDriveN;
  logic wrFire, wrTimer, mEvt, tick;
  logic [31:0] wrVal;
  logic [2:0] startTrig, stopTrig, runNow;
  logic [3:0] tick4;
  logic [1:0] toBit, dutyEnd, valWr;
  slaveCfg_s cfg [2];

  // ----------------------------------------
  // bus slave: address and data taken in either order
  // ----------------------------------------
  always_comb
  begin
    nxt_awHeld = awHeld_ff;
    nxt_awAddr = awAddr_ff;
    nxt_wHeld = wHeld_ff;
    nxt_wData = wData_ff;
    nxt_wStrb = wStrb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    if (s_axi_awvalid && awready_ff)
    begin
      nxt_awHeld = 1'b1;
      nxt_awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_ff)
    begin
      nxt_wHeld = 1'b1;
      nxt_wData = s_axi_wdata;
      nxt_wStrb = s_axi_wstrb;
    end
    if (bvalid_ff && s_axi_bready)
    begin
      nxt_bvalid = 1'b0;
    end
    if (wrFire)
    begin
      nxt_awHeld = 1'b0;
      nxt_wHeld = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = regHit(awAddr_ff) ? RESP_OKAY : RESP_SLVERR;
    end
    nxt_awready = !nxt_awHeld && !nxt_bvalid;
    nxt_wready = !nxt_wHeld && !nxt_bvalid;
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    if (rvalid_ff && s_axi_rready)
    begin
      nxt_rvalid = 1'b0;
    end
    if (s_axi_arvalid && arready_ff)
    begin
      nxt_rvalid = 1'b1;
      nxt_rdata = rdMux;
      nxt_rresp = regHit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    nxt_arready = !nxt_rvalid;
  end

  assign wrFire = awHeld_ff && wHeld_ff && !bvalid_ff;
  assign wrTimer = wrFire && perEn_ff; // RULE1
  assign wrVal = wData_ff;

  always_comb
  begin
    rdMux = 32'h0000_0000;
    case (s_axi_araddr)
      PER_EN_OFS: rdMux = 32'(perEn_ff);
      PRESCALE_OFS: rdMux = 32'(psc_ff);
      MMODE_OFS: rdMux = 32'(mMode_ff);
      SMODE_OFS: rdMux = 32'(sMode_ff);
      PERIOD_OFS: rdMux = 32'(period_ff);
      DUTY1_OFS: rdMux = 32'(duty_ff[0]);
      DUTY2_OFS: rdMux = 32'(duty_ff[1]);
      OUTMODE_OFS: rdMux = 32'({outMode_ff[7:6], toBit, outMode_ff[3:0]});
      START_OFS: rdMux = 32'h0000_0000; // RULE13
      STATUS_OFS: rdMux = 32'(run_ff);
      PORT_OFS: rdMux = 32'(port_ff);
      MCOUNT_OFS: rdMux = 32'(mCnt_ff);
      SCOUNT1_OFS: rdMux = 32'(sCnt[0]);
      SCOUNT2_OFS: rdMux = 32'(sCnt[1]);
      default: rdMux = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------
  // registers written by software
  // ----------------------------------------
  always_comb
  begin
    nxt_perEn = perEn_ff;
    nxt_psc = psc_ff;
    nxt_mMode = mMode_ff;
    nxt_sMode = sMode_ff;
    nxt_period = period_ff;
    nxt_duty = duty_ff;
    nxt_outMode = outMode_ff;
    nxt_port = port_ff;
    startTrig = 3'h0;
    stopTrig = 3'h0;
    valWr = 2'h0;
    if (wrFire && awAddr_ff == PER_EN_OFS)
    begin
      nxt_perEn = 1'(wmerge(32'(perEn_ff), wrVal, wStrb_ff)); // RULE2
    end
    if (wrFire && awAddr_ff == PORT_OFS)
    begin
      nxt_port = 4'(wmerge(32'(port_ff), wrVal, wStrb_ff));
    end
    if (wrTimer)
    begin
      case (awAddr_ff)
        PRESCALE_OFS: nxt_psc = 16'(wmerge(32'(psc_ff), wrVal, wStrb_ff));
        MMODE_OFS: nxt_mMode = 2'(wmerge(32'(mMode_ff), wrVal, wStrb_ff));
        SMODE_OFS: nxt_sMode = 2'(wmerge(32'(sMode_ff), wrVal, wStrb_ff));
        PERIOD_OFS: nxt_period = 16'(wmerge(32'(period_ff), wrVal, wStrb_ff)); // RULE21
        DUTY1_OFS: nxt_duty[0] = 16'(wmerge(32'(duty_ff[0]), wrVal, wStrb_ff));
        DUTY2_OFS: nxt_duty[1] = 16'(wmerge(32'(duty_ff[1]), wrVal, wStrb_ff));
        OUTMODE_OFS:
        begin
          nxt_outMode = 8'(wmerge(32'(outMode_ff), wrVal, wStrb_ff));
          valWr = {2{wStrb_ff[0]}};
        end
        START_OFS: startTrig = wStrb_ff[0] ? wrVal[2:0] : 3'h0; // RULE13
        STOP_OFS: stopTrig = wStrb_ff[0] ? wrVal[2:0] : 3'h0;
        default: startTrig = 3'h0;
      endcase
    end
    if (!perEn_ff)
    begin
      nxt_psc = PSC_RST;
      nxt_mMode = 2'h0;
      nxt_sMode = 2'h0;
      nxt_period = '0;
      nxt_duty = '{default: '0};
      nxt_outMode = 8'h00;
    end
  end

  // ----------------------------------------
  // master channel and run status
  // ----------------------------------------
  assign runNow = (run_ff | startTrig) & ~stopTrig; // RULE14 RULE20
  assign tick = tick4[mMode_ff];
  assign mEvt = runNow[0] && (startTrig[0] || (tick && mCnt_ff == '0)); // RULE15 RULE16

  always_comb
  begin
    nxt_run = perEn_ff ? runNow : 3'h0; // RULE2
    nxt_mCnt = mCnt_ff;
    if (!perEn_ff)
    begin
      nxt_mCnt = '0;
    end
    else if (mEvt)
    begin
      nxt_mCnt = period_ff; // RULE16 RULE21
    end
    else if (runNow[0] && tick)
    begin
      nxt_mCnt = mCnt_ff - 16'h0001;
    end
    nxt_mEvtQ = mEvt;
    for (int i = 0; i < 2; i++)
    begin
      nxt_pwmOut[i] = toBit[i];
      nxt_pwmDriveN[i] = port_ff[PORT_LATCH_LSB+i] || port_ff[PORT_MODE_LSB+i]; // RULE9
    end
  end

  pwm_prescaler u_prescaler (
    .clk(clk),
    .rstn(rstn),
    .en(perEn_ff),
    .sel(psc_ff),
    .tick(tick4)
  );

  for (genvar g = 0; g < 2; g++)
  begin : gSlave
    assign cfg[g] = '{mode: outMode_ff[OUT_MODE_LSB+g], level: outMode_ff[OUT_LVL_LSB+g],
      enable: outMode_ff[OUT_EN_LSB+g]};
    pwm_slave_channel u_slave (
      .clk(clk),
      .rstn(rstn),
      .clear(!perEn_ff),
      .tick(tick),
      .mEvt(mEvt),
      .run(runNow[g+1]),
      .duty(duty_ff[g]),
      .cfg(cfg[g]),
      .valWr(valWr[g]),
      .valIn(wrVal[OUT_VAL_LSB+g]),
      .toBit(toBit[g]),
      .cnt(sCnt[g]),
      .dutyEnd(dutyEnd[g])
    );
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      awHeld_ff <= 1'b0;
      awAddr_ff <= '0;
      wHeld_ff <= 1'b0;
      wData_ff <= 32'h0000_0000;
      wStrb_ff <= 4'h0;
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= RESP_OKAY;
      perEn_ff <= 1'b0;
      psc_ff <= PSC_RST;
      mMode_ff <= 2'h0;
      sMode_ff <= 2'h0;
      period_ff <= '0;
      duty_ff <= '{default: '0};
      outMode_ff <= 8'h00;
      port_ff <= PORT_RST;
      run_ff <= 3'h0;
      mCnt_ff <= '0;
      mEvtQ_ff <= 1'b0;
      pwmOut_ff <= 2'h0;
      pwmDriveN_ff <= 2'h3;
    end
    else
    begin
      awHeld_ff <= nxt_awHeld;
      awAddr_ff <= nxt_awAddr;
      wHeld_ff <= nxt_wHeld;
      wData_ff <= nxt_wData;
      wStrb_ff <= nxt_wStrb;
      awready_ff <= nxt_awready;
      wready_ff <= nxt_wready;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      arready_ff <= nxt_arready;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
      perEn_ff <= nxt_perEn;
      psc_ff <= nxt_psc;
      mMode_ff <= nxt_mMode;
      sMode_ff <= nxt_sMode;
      period_ff <= nxt_period;
      duty_ff <= nxt_duty;
      outMode_ff <= nxt_outMode;
      port_ff <= nxt_port;
      run_ff <= nxt_run;
      mCnt_ff <= nxt_mCnt;
      mEvtQ_ff <= nxt_mEvtQ;
      pwmOut_ff <= nxt_pwmOut;
      pwmDriveN_ff <= nxt_pwmDriveN;
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign pwmOut = pwmOut_ff;
  assign pwmDriveN = pwmDriveN_ff;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cbA @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_start;
    startTrig[0] && !stopTrig[0] && perEn_ff;
  endsequence

  property p_gated;
    !perEn_ff |=> (run_ff == 3'h0) && (tick4 == 4'h0);
  endproperty
  a_gated: assert property (p_gated) else $error("count clocks or run bits while unit disabled"); // RULE1

  property p_ignore_wr;
    wrFire && !perEn_ff && awAddr_ff == PERIOD_OFS |=> period_ff == '0;
  endproperty
  a_ignore_wr: assert property (p_ignore_wr) else $error("timer write accepted while unit disabled"); // RULE1

  property p_enable_stopped;
    $rose(perEn_ff) |-> run_ff == 3'h0;
  endproperty
  a_enable_stopped: assert property (p_enable_stopped) else $error("channel running at enable"); // RULE2

  property p_start_reads_zero;
    s_axi_arvalid && arready_ff && s_axi_araddr == START_OFS |=> rdata_ff == 32'h0000_0000;
  endproperty
  a_start_reads_zero: assert property (p_start_reads_zero) else $error("start register read non-zero"); // RULE13

  property p_start_run;
    s_start |=> run_ff[0] && mEvtQ_ff && (mCnt_ff == $past(period_ff));
  endproperty
  a_start_run: assert property (p_start_run) else $error("start did not run master with event"); // RULE14 RULE15

  property p_reload;
    run_ff[0] && !stopTrig[0] && !startTrig[0] && tick && mCnt_ff == '0 && perEn_ff
      |=> mEvtQ_ff && mCnt_ff == $past(period_ff);
  endproperty
  a_reload: assert property (p_reload) else $error("master failed to reload at zero"); // RULE16

  property p_slave_load;
    mEvt && runNow[1] && perEn_ff |=> sCnt[0] == $past(duty_ff[0]);
  endproperty
  a_slave_load: assert property (p_slave_load) else $error("slave did not load duty on event"); // RULE17

  property p_end_inactive;
    dutyEnd[0] && cfg[0].mode && cfg[0].enable && perEn_ff |-> toBit[0] == cfg[0].level;
  endproperty
  a_end_inactive: assert property (p_end_inactive) else $error("slave output active at count end"); // RULE18

  property p_stop_freeze;
    stopTrig[0] && perEn_ff |=> !run_ff[0] && $stable(mCnt_ff);
  endproperty
  a_stop_freeze: assert property (p_stop_freeze) else $error("stop did not freeze master"); // RULE20

  property p_stopped_hold;
    perEn_ff && !runNow[1] && !valWr[0] |=> $stable(toBit[0]);
  endproperty
  a_stopped_hold: assert property (p_stopped_hold) else $error("stopped slave output moved"); // RULE10

  property p_pin_drive;
    port_ff[PORT_LATCH_LSB] || port_ff[PORT_MODE_LSB] |=> pwmDriveN_ff[0];
  endproperty
  a_pin_drive: assert property (p_pin_drive) else $error("pin driven before port handoff"); // RULE9
endmodule // multi_pwm_timer_group
`default_nettype wire

/* File: verif/multi_pwm_timer_group_test.sv */
`timescale 1ns/1ns
`default_nettype none
module multi_pwm_timer_group_test;
  import pwm_group_pkg::*;
  logic clk, rstn, awValid, wValid, bReady, arValid, rReady;
  logic awReady, wReady, bValid, arReady, rValid;
  logic [7:0] awAddr, arAddr;
  logic [31:0] wData, rData, got;
  logic [3:0] wStrb;
  logic [1:0] bResp, rResp, resp, pwmOut, pwmDriveN, held;
  int fails = 0;
  int compares = 0;
  int cycles = 0;
  int per, d1, d2, h1, h2;

  multi_pwm_timer_group i_dut (.clk(clk), .rstn(rstn), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
    .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
    .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
    .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady), .pwmOut(pwmOut),
    .pwmDriveN(pwmDriveN));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      fails++;
      close_out();
    end
  end

  // ---------------------------------------------
  // bus and compare tasks
  // ---------------------------------------------
  task automatic close_out;
    $display("counts: %0d compares, %0d fails", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    awAddr <= a;
    wData <= d;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awReady === 1'b1)
        awValid <= 1'b0;
      if (wReady === 1'b1)
        wValid <= 1'b0;
    end
    while (bValid !== 1'b1);
    r = bResp;
    bReady <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arReady === 1'b1)
        arValid <= 1'b0;
    end
    while (rValid !== 1'b1);
    d = rData;
    r = rResp;
    rReady <= 1'b0;
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a, got, resp);
    chk(got, e);
    chk(resp, RESP_OKAY);
  endtask

  // model: active count clocks over k periods
  function automatic int expHigh(input int d, input int p, input int k);
    return k * ((d > p) ? p + 1 : d);
  endfunction

  task automatic meas(input int n);
    h1 = 0;
    h2 = 0;
    repeat (n)
    begin
      @(posedge clk);
      if (pwmOut[0] === 1'b1)
        h1++;
      if (pwmOut[1] === 1'b1)
        h2++;
    end
  endtask

  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial
  begin
    rstn = 1'b0;
    {awValid, wValid, bReady, arValid, rReady} = 5'b0;
    awAddr = 8'h00;
    arAddr = 8'h00;
    wData = 32'h0000_0000;
    wStrb = 4'hF;
    void'($urandom(83830));
    repeat (8) @(posedge clk);
    chk(pwmDriveN, 2'b11);
    rstn <= 1'b1;
    wr(PERIOD_OFS, 32'h0000_0005, resp);
    rc(PERIOD_OFS, 32'h0000_0000);
    wr(PER_EN_OFS, 32'h0000_0001, resp);
    rc(STATUS_OFS, 32'h0000_0000);
    rc(PORT_OFS, {28'h0, PORT_RST});
    $display("test enable done");
    per = $urandom_range(12, 3);
    d1 = $urandom_range(per, 1);
    d2 = per + 2 + $urandom_range(3, 0);
    wr(PRESCALE_OFS, 32'h0000_0000, resp);
    wr(MMODE_OFS, 32'h0000_0000, resp);
    wr(SMODE_OFS, 32'h0000_0000, resp);
    wr(PERIOD_OFS, per, resp);
    wr(DUTY1_OFS, d1, resp);
    wr(DUTY2_OFS, d2, resp);
    rc(DUTY2_OFS, d2);
    wr(OUTMODE_OFS, 32'h0000_00D3, resp);
    repeat (3) @(posedge clk);
    chk(pwmDriveN, 2'b11);
    wr(PORT_OFS, 32'h0000_0000, resp);
    repeat (3) @(posedge clk);
    chk(pwmDriveN, 2'b00);
    chk(pwmOut, 2'b01);
    repeat (20) @(posedge clk);
    chk(pwmOut, 2'b01);
    wr(OUTMODE_OFS, 32'h0000_00C3, resp);
    repeat (3) @(posedge clk);
    chk(pwmOut, 2'b00);
    $display("test config done");
    wr(START_OFS, 32'h0000_0007, resp);
    rc(START_OFS, 32'h0000_0000);
    rc(STATUS_OFS, 32'h0000_0007);
    repeat (3 * (per + 1)) @(posedge clk);
    meas(4 * (per + 1));
    chk(h1, expHigh(d1, per, 4));
    chk(h2, expHigh(d2, per, 4));
    $display("test run done");
    d1 = $urandom_range(per, 1);
    wr(DUTY1_OFS, d1, resp);
    repeat (2 * (per + 1) + 4) @(posedge clk);
    meas(4 * (per + 1));
    chk(h1, expHigh(d1, per, 4));
    $display("test reload done");
    wr(STOP_OFS, 32'h0000_0007, resp);
    rc(STATUS_OFS, 32'h0000_0000);
    rd(MCOUNT_OFS, got, resp);
    held = pwmOut;
    repeat (10) @(posedge clk);
    rc(MCOUNT_OFS, got);
    chk(pwmOut, held);
    rd(8'h3C, got, resp);
    chk(resp, RESP_SLVERR);
    wr(8'h40, 32'h0000_0001, resp);
    chk(resp, RESP_SLVERR);
    $display("test stop done");
    wr(OUTMODE_OFS, 32'h0000_00C3, resp);
    wr(START_OFS, 32'h0000_0007, resp);
    rc(STATUS_OFS, 32'h0000_0007);
    wr(PER_EN_OFS, 32'h0000_0000, resp);
    rc(STATUS_OFS, 32'h0000_0000);
    wr(PERIOD_OFS, 32'h0000_0009, resp);
    rc(PERIOD_OFS, 32'h0000_0000);
    $display("test disable done");
    close_out();
  end
endmodule // multi_pwm_timer_group_test
`default_nettype wire
